// ### core/amprbc_core.sv
`timescale 1ns/1ps
`default_nettype none
module amprbc_core
    import amprbc_pkg::*;
#(
    parameter int SOFT_CYCLES = SOFT_MUTE_CYC,
    parameter int HARD_CYCLES = HARD_MUTE_CYC,
    parameter int LEVEL_W = 21
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic linkClk,
    input wire logic reset,
    // Byte link from the bus front end
    input wire amprbc_link_t link,
    output logic [BYTE_W-1:0] readByte,
    // Analog sense inputs, asynchronous
    input wire amprbc_sense_t sense,
    // Control
    input wire logic diagEnable,
    // Amplifier
    output logic ampOn,
    output logic lineDriverBias,
    output logic [PAIR_COUNT-1:0] pairSilent,
    output logic [PAIR_COUNT-1:0] pairFull,
    // Diag pin, open drain
    output logic diagOut,
    output logic diagOe,
    // Regulators and switches
    output amprbc_power_t power
);

    localparam logic [LEVEL_W-1:0] LEVEL_MAX = LEVEL_W'(SOFT_CYCLES);
    localparam logic [LEVEL_W-1:0] HARD_STEP =
        LEVEL_W'((SOFT_CYCLES + HARD_CYCLES - 1) / HARD_CYCLES);
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] IB_LAST = ADDR_W'(IB_COUNT - 1);
    localparam logic [ADDR_W-1:0] DB_ALL = ADDR_W'(DB_COUNT);

    // Link domain state
    logic [BYTE_W-1:0] wrHold_r [IB_COUNT];
    logic [IB_COUNT-1:0] wrMask_r;
    logic [ADDR_W-1:0] linkIdx_r;
    logic frameRead_r;
    logic wrTog_r;
    logic snapTog_r;
    logic clrTog_r;
    logic [BYTE_W-1:0] readByte_r;

    // Core domain state
    logic [$bits(amprbc_sense_t)-1:0] senS1_r, senS2_r, senS3_r;
    amprbc_sense_t sen_r;
    logic [2:0] togS1_r, togS2_r, togS3_r, tog_r;
    logic stbPrev_r;
    logic [BYTE_W-1:0] ib_r [IB_COUNT];
    logic porFlag_r;
    logic [31:0] diagLat_r;
    logic [31:0] snap_r;
    amprbc_amp_t ampState_r;
    logic [LEVEL_W-1:0] level_r [PAIR_COUNT];
    logic [PAIR_COUNT-1:0] pairSilent_r, pairFull_r;
    logic ampOn_r, lineDrv_r, diagLow_r;
    amprbc_power_t power_r;

    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            linkIdx_r <= '0;
            frameRead_r <= 1'b0;
            wrMask_r <= '0;
        end else if (link.start) begin
            linkIdx_r <= '0;
            frameRead_r <= link.rnw;
            wrMask_r <= link.rnw ? wrMask_r : '0;
        end else if (link.byteStb && linkIdx_r <= IB_LAST) begin
            linkIdx_r <= linkIdx_r + 1'b1;
            if (!frameRead_r) begin
                wrMask_r[linkIdx_r] <= 1'b1;
            end
        end
    end

    // Held until the next write frame; core copies it on the toggle
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < IB_COUNT; i++) begin
                wrHold_r[i] <= IB_RESET;
            end
        end else if (link.byteStb && !frameRead_r && linkIdx_r <= IB_LAST) begin
            wrHold_r[linkIdx_r] <= link.data;
        end
    end

    // clear toggle only after four bytes
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            wrTog_r <= 1'b0;
            snapTog_r <= 1'b0;
            clrTog_r <= 1'b0;
        end else begin
            if (link.start && link.rnw) begin
                snapTog_r <= ~snapTog_r;
            end
            if (link.stop && !frameRead_r && wrMask_r != '0) begin
                wrTog_r <= ~wrTog_r;
            end
            if (link.stop && frameRead_r && linkIdx_r >= DB_ALL) begin
                clrTog_r <= ~clrTog_r;
            end
        end
    end

    // Snapshot is stable well before the first data byte is clocked
    always_ff @(posedge linkClk or posedge reset) begin
        if (reset) begin
            readByte_r <= IB_RESET;
        end else if (link.byteStb && frameRead_r && linkIdx_r < DB_ALL) begin
            readByte_r <= snap_r[linkIdx_r[1:0]*BYTE_W +: BYTE_W];
        end
    end

    // three-stage sync, accept when stages agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            senS1_r <= '0;
            senS2_r <= '0;
            senS3_r <= '0;
            sen_r <= '0;
            togS1_r <= TOG_RESET;
            togS2_r <= TOG_RESET;
            togS3_r <= TOG_RESET;
            tog_r <= TOG_RESET;
        end else begin
            senS1_r <= sense;
            senS2_r <= senS1_r;
            senS3_r <= senS2_r;
            sen_r <= (senS2_r & senS3_r) | (sen_r & (senS2_r | senS3_r));
            togS1_r <= {clrTog_r, snapTog_r, wrTog_r};
            togS2_r <= togS1_r;
            togS3_r <= togS2_r;
            tog_r <= (togS2_r & togS3_r) | (tog_r & (togS2_r | togS3_r));
        end
    end

    logic [2:0] togNxt;
    logic wrEvt, snapEvt, clrEvt, stbRise;
    assign togNxt = (togS2_r & togS3_r) | (tog_r & (togS2_r | togS3_r));
    assign wrEvt = togNxt[0] ^ tog_r[0];
    assign snapEvt = togNxt[1] ^ tog_r[1];
    assign clrEvt = togNxt[2] ^ tog_r[2];
    assign stbRise = sen_r.standby && !stbPrev_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stbPrev_r <= 1'b0;
        end else begin
            stbPrev_r <= sen_r.standby;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < IB_COUNT; i++) begin
                ib_r[i] <= IB_RESET;
            end
        end else if (stbRise) begin
            for (int i = 0; i < IB_COUNT; i++) begin
                ib_r[i] <= IB_RESET;
            end
        end else if (wrEvt) begin
            for (int i = 0; i < IB_COUNT; i++) begin
                if (wrMask_r[i]) begin
                    ib_r[i] <= wrHold_r[i];
                end
            end
        end
    end

    logic startBit;
    assign startBit = ib_r[IB_ONE][AMP_START_BIT];

    // POR flag set on standby rise, set wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            porFlag_r <= 1'b0;
        end else if (stbRise) begin
            porFlag_r <= 1'b1;
        end else if (startBit) begin
            porFlag_r <= 1'b0;
        end
    end

    logic [31:0] liveDiag;
    always_comb begin
        liveDiag = sen_r.ampFail;
        liveDiag[POR_FLAG_POS] = porFlag_r;
        liveDiag[REG_TEMP_POS] = sen_r.regTempHigh;
    end

    // sticky latches, live events win over the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            diagLat_r <= '0;
        end else if (clrEvt) begin
            diagLat_r <= liveDiag;
        end else begin
            diagLat_r <= diagLat_r | liveDiag;
        end
    end

    // read shows latches taken at frame start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            snap_r <= '0;
        end else if (snapEvt) begin
            snap_r <= diagLat_r;
        end
    end

    // standby low or start cleared hard mutes before shutdown
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ampState_r <= AMP_OFF;
        end else begin
            case (ampState_r)
                AMP_OFF: begin
                    if (startBit && sen_r.standby && !sen_r.regTempHigh) begin
                        ampState_r <= AMP_RUN;
                    end
                end
                AMP_RUN: begin
                    if (!startBit || !sen_r.standby || sen_r.regTempHigh) begin
                        ampState_r <= AMP_DOWN;
                    end
                end
                AMP_DOWN: begin
                    if (pairSilent_r == '1) begin
                        ampState_r <= AMP_OFF;
                    end
                end
                default: ampState_r <= AMP_OFF;
            endcase
        end
    end

    logic hardReq;
    // fast mute bit or shutdown forces hard mute
    assign hardReq = ib_r[IB_TWO][FAST_MUTE_BIT] || ampState_r == AMP_DOWN;

    genvar p;
    generate
        for (p = 0; p < PAIR_COUNT; p++) begin : gPair
            logic softReq;
            logic [LEVEL_W-1:0] levelNxt;
            // per pair soft mute, also the all-channel bit
            assign softReq = ib_r[IB_TWO][SOFT_MUTE_BIT]
                || ib_r[IB_FIVE][PAIR_MUTE_LSB + p];
            always_comb begin
                levelNxt = level_r[p];
                if (ampState_r == AMP_OFF) begin
                    levelNxt = '0;
                // large steps finish within the hard time
                end else if (hardReq) begin
                    levelNxt = (level_r[p] > HARD_STEP) ?
                        level_r[p] - HARD_STEP : '0;
                end else if (softReq) begin
                    levelNxt = (level_r[p] != '0) ?
                        level_r[p] - 1'b1 : '0;
                // unmute is always the slow ramp
                end else if (level_r[p] < LEVEL_MAX) begin
                    levelNxt = level_r[p] + 1'b1;
                end
            end
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    level_r[p] <= '0;
                    pairSilent_r[p] <= 1'b1;
                    pairFull_r[p] <= 1'b0;
                end else begin
                    level_r[p] <= levelNxt;
                    pairSilent_r[p] <= levelNxt == '0;
                    pairFull_r[p] <= levelNxt == LEVEL_MAX;
                end
            end
        end
    endgenerate

    // select counts only with both pairs at 16 dB
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lineDrv_r <= 1'b0;
            ampOn_r <= 1'b0;
        end else begin
            // one selects 0.23 supply; zero half supply
            lineDrv_r <= ib_r[IB_THREE][GAIN_FRONT_BIT]
                && ib_r[IB_THREE][GAIN_REAR_BIT]
                && ib_r[IB_FOUR][LINE_DRV_BIT];
            ampOn_r <= ampState_r != AMP_OFF;
        end
    end

    // live failures drive the pin, not the latches
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            diagLow_r <= 1'b1;
        end else begin
            // low after POR until started; start releases
            diagLow_r <= !startBit || sen_r.regTempHigh
                || (diagEnable && (|sen_r.ampFail));
        end
    end

    logic regKill, swKill;
    assign regKill = sen_r.overVolt || sen_r.regTempMax;
    // switches off above 22 V, restored below
    assign swKill = regKill || sen_r.battOver22;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_r <= '0;
            power_r.reg2On <= 1'b1;
            power_r.reg6On <= 1'b1;
        end else begin
            // own overtemperature shuts each one off, except reg2On and reg6On, which stay on
            power_r.reg1Sel <= (regKill || sen_r.regOverTemp[0]) ? '0 :
                ib_r[IB_TWO][REG1_LSB +: 2];
            power_r.reg3On <= !(regKill || sen_r.regOverTemp[1])
                && ib_r[IB_TWO][REG3_BIT];
            power_r.reg4Sel <= (regKill || sen_r.regOverTemp[2]) ? '0 :
                ib_r[IB_TWO][REG4_LSB +: 3];
            power_r.reg5Sel <= (regKill || sen_r.regOverTemp[3]) ? '0 :
                ib_r[IB_ONE][REG5_LSB +: 4];
            power_r.reg2On <= 1'b1;
            power_r.reg6On <= 1'b1;
            power_r.sw1On <= !(swKill || sen_r.swOverTemp[0])
                && ib_r[IB_ONE][SW1_BIT];
            power_r.sw2On <= !(swKill || sen_r.swOverTemp[1])
                && ib_r[IB_ONE][SW2_BIT];
        end
    end

    assign readByte = readByte_r;
    assign ampOn = ampOn_r;
    assign lineDriverBias = lineDrv_r;
    assign pairSilent = pairSilent_r;
    assign pairFull = pairFull_r;
    assign diagOut = 1'b0;
    assign diagOe = diagLow_r;
    assign power = power_r;

endmodule
`default_nettype wire

// ### core/amprbc_pkg.sv
package amprbc_pkg;

    localparam int IB_COUNT = 5;
    localparam int DB_COUNT = 4;
    localparam int BYTE_W = 8;

    // Instruction byte indices
    localparam int IB_ONE = 0;
    localparam int IB_TWO = 1;
    localparam int IB_THREE = 2;
    localparam int IB_FOUR = 3;
    localparam int IB_FIVE = 4;

    // Instruction byte one
    localparam int AMP_START_BIT = 0;
    localparam int SW1_BIT = 2;
    localparam int SW2_BIT = 3;
    localparam int REG5_LSB = 4;
    // Instruction byte two
    localparam int FAST_MUTE_BIT = 0;
    localparam int SOFT_MUTE_BIT = 1;
    localparam int REG1_LSB = 2;
    localparam int REG3_BIT = 4;
    localparam int REG4_LSB = 5;
    // Instruction byte three
    localparam int GAIN_REAR_BIT = 5;
    localparam int GAIN_FRONT_BIT = 6;
    // Instruction byte four
    localparam int LINE_DRV_BIT = 4;
    // Instruction byte five: per pair soft mute, pair 0 front
    localparam int PAIR_MUTE_LSB = 0;

    // Data byte two flags, as bit positions in the 32-bit diag word
    localparam int POR_FLAG_POS = 15;
    localparam int REG_TEMP_POS = 14;

    localparam logic [BYTE_W-1:0] IB_RESET = 8'h00;
    localparam logic [2:0] TOG_RESET = 3'h0;

    // Timing
    localparam int CLK_FREQ_MHZ = 100;
    localparam int SOFT_MUTE_US = 15000;
    localparam int HARD_MUTE_US = 400;
    localparam int SOFT_MUTE_CYC = SOFT_MUTE_US * CLK_FREQ_MHZ;
    localparam int HARD_MUTE_CYC = HARD_MUTE_US * CLK_FREQ_MHZ;
    localparam int PAIR_COUNT = 2;

    typedef struct packed {
        logic start;
        logic stop;
        logic rnw;
        logic byteStb;
        logic [BYTE_W-1:0] data;
    } amprbc_link_t;

    typedef struct packed {
        logic standby;
        logic battOver22;
        logic overVolt;
        logic regTempHigh;
        logic regTempMax;
        logic [3:0] regOverTemp;
        logic [1:0] swOverTemp;
        logic [31:0] ampFail;
    } amprbc_sense_t;

    typedef struct packed {
        logic [1:0] reg1Sel;
        logic reg3On;
        logic [2:0] reg4Sel;
        logic [3:0] reg5Sel;
        logic reg2On;
        logic reg6On;
        logic sw1On;
        logic sw2On;
    } amprbc_power_t;

    typedef enum logic [1:0] {
        AMP_OFF,
        AMP_RUN,
        AMP_DOWN
    } amprbc_amp_t;

endpackage

// ### dv/amprbc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module amprbc_chk
    import amprbc_pkg::*;
#(
    parameter int SOFT_CYCLES = 60,
    parameter int HARD_CYCLES = 8
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic linkClk,
    input wire logic reset,
    // Link, sense and control
    input wire amprbc_link_t link,
    input wire logic [BYTE_W-1:0] readByte,
    input wire amprbc_sense_t sense,
    input wire logic diagEnable,
    // Amplifier and diag
    input wire logic ampOn,
    input wire logic lineDriverBias,
    input wire logic [PAIR_COUNT-1:0] pairSilent,
    input wire logic [PAIR_COUNT-1:0] pairFull,
    input wire logic diagOut,
    input wire logic diagOe,
    // Regulators and switches
    input wire amprbc_power_t power
);
    logic switchedOff;
    // Sense passes a 3-flop sync, so holds of 8 cycles leave margin
    assign switchedOff = ({power.reg1Sel, power.reg3On, power.reg4Sel,
        power.reg5Sel, power.sw1On, power.sw2On} == 12'h000);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_ovHeld; sense.overVolt[*8]; endsequence
    sequence s_stbLow; (!sense.standby)[*8]; endsequence
    property p_standby_regs; power.reg2On && power.reg6On; endproperty
    property p_overvolt_off; s_ovHeld |-> switchedOff; endproperty
    property p_tempmax_off; sense.regTempMax[*8] |-> switchedOff; endproperty
    property p_batt_switch;
        sense.battOver22[*8] |-> !power.sw1On && !power.sw2On;
    endproperty
    property p_reg1_temp;
        sense.regOverTemp[0][*8] |-> power.reg1Sel == 2'h0;
    endproperty
    property p_temp_diag;
        sense.regTempHigh[*8] |-> diagOe && !$rose(ampOn);
    endproperty
    property p_fail_diag;
        (diagEnable && (|sense.ampFail))[*8] |-> diagOe;
    endproperty
    property p_mute_first; $fell(ampOn) |-> &pairSilent; endproperty
    // Long standby low: hard mute and shutdown must be over
    property p_standby_down;
        s_stbLow ##1 s_stbLow ##1 s_stbLow |-> !ampOn;
    endproperty
    property p_unmute_soft;
        $fell(pairSilent[0]) |-> !pairFull[0] [*8];
    endproperty
    a_standby_regs: assert property (p_standby_regs)
        else $error("standby regulator off");
    a_overvolt_off: assert property (p_overvolt_off)
        else $error("outputs on in overvoltage");
    a_tempmax_off: assert property (p_tempmax_off)
        else $error("outputs on at max temperature");
    a_batt_switch: assert property (p_batt_switch)
        else $error("switch on above battery limit");
    a_reg1_temp: assert property (p_reg1_temp)
        else $error("regulator 1 on in overtemperature");
    a_temp_diag: assert property (p_temp_diag)
        else $error("temperature high not shown or amp started");
    a_fail_diag: assert property (p_fail_diag)
        else $error("live failure not on diag pin");
    a_mute_first: assert property (p_mute_first)
        else $error("amp off before pairs silent");
    a_standby_down: assert property (p_standby_down)
        else $error("amp still on long after standby low");
    a_unmute_soft: assert property (p_unmute_soft)
        else $error("unmute too fast");
endmodule
bind amprbc_core amprbc_chk #(
    .SOFT_CYCLES(SOFT_CYCLES),
    .HARD_CYCLES(HARD_CYCLES)
) u_amprbc_chk (
    .clk(clk), .linkClk(linkClk), .reset(reset), .link(link),
    .readByte(readByte), .sense(sense), .diagEnable(diagEnable),
    .ampOn(ampOn), .lineDriverBias(lineDriverBias),
    .pairSilent(pairSilent), .pairFull(pairFull), .diagOut(diagOut),
    .diagOe(diagOe), .power(power)
);
`default_nettype wire

// ### dv/amprbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module amprbc_host
    import amprbc_pkg::*;
(
    // Link clock and byte link
    output logic linkClk,
    output amprbc_link_t link,
    // Read data
    input wire logic [BYTE_W-1:0] readByte
);
    logic run;
    initial begin
        linkClk = 1'b0;
        run = 1'b0;
        link = '0;
    end
    // Link clock stands still low between frames
    always begin
        #16;
        if (run || linkClk) linkClk = ~linkClk;
    end
    task automatic frameStart(input logic rnw);
        run = 1'b1;
        @(posedge linkClk);
        link.start <= 1'b1;
        link.rnw <= rnw;
        @(posedge linkClk);
        link.start <= 1'b0;
    endtask
    task automatic frameStop;
        link.stop <= 1'b1;
        @(posedge linkClk);
        link.stop <= 1'b0;
        repeat (2) @(posedge linkClk);
        run = 1'b0;
    endtask
    task automatic writeFrame(input logic [39:0] bytes);
        frameStart(1'b0);
        link.byteStb <= 1'b1;
        for (int k = 0; k < IB_COUNT; k++) begin
            link.data <= bytes[8*k+:8];
            @(posedge linkClk);
        end
        link.byteStb <= 1'b0;
        // Released data shows garbage, not the last byte
        link.data <= ~bytes[39:32];
        frameStop();
    endtask
    // fewer than four bytes keeps latches
    task automatic readFrame(input int n, output logic [31:0] word);
        word = '0;
        frameStart(1'b1);
        repeat (8) @(posedge linkClk);
        for (int k = 0; k < n; k++) begin
            link.byteStb <= 1'b1;
            @(posedge linkClk);
            link.byteStb <= 1'b0;
            @(posedge linkClk);
            word[8*k+:8] = readByte;
        end
        frameStop();
    endtask
endmodule
`default_nettype wire

// ### dv/amprbc_bench.sv
`timescale 1ns/1ps
`default_nettype none
module amprbc_bench
    import amprbc_pkg::*;
;
    localparam int SOFT = 60;
    localparam int HARD = 8;
    logic clk;
    logic reset;
    logic linkClk;
    amprbc_link_t link;
    logic [BYTE_W-1:0] readByte;
    amprbc_sense_t sense;
    logic diagEnable;
    logic ampOn;
    logic lineDriverBias;
    logic [PAIR_COUNT-1:0] pairSilent;
    logic [PAIR_COUNT-1:0] pairFull;
    logic diagOut;
    logic diagOe;
    amprbc_power_t power;
    int errors;
    int checks;
    logic [31:0] word;
    logic [7:0] gainTab [5] = '{8'h00, 8'h40, 8'h20, 8'h60, 8'h60};
    // ib2, ib5, early silent, late silent
    logic [23:0] muteTab [4] = '{24'h55_00_33, 24'h56_00_03,
        24'h54_01_01, 24'h54_02_02};
    logic [13:0] protTab [4] = '{14'h000c, 14'h1a3c, 14'h000c, 14'h0a3f};
    initial clk = 1'b0;
    always #5 clk = ~clk;
    amprbc_core #(.SOFT_CYCLES(SOFT), .HARD_CYCLES(HARD)) u_amprbc_core (
        .clk(clk), .linkClk(linkClk), .reset(reset), .link(link),
        .readByte(readByte), .sense(sense), .diagEnable(diagEnable),
        .ampOn(ampOn), .lineDriverBias(lineDriverBias),
        .pairSilent(pairSilent), .pairFull(pairFull), .diagOut(diagOut),
        .diagOe(diagOe), .power(power)
    );
    amprbc_host u_amprbc_host (
        .linkClk(linkClk), .link(link), .readByte(readByte)
    );
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Settle time covers the crossing into the core clock
    task automatic wr(input logic [39:0] b);
        u_amprbc_host.writeFrame(b);
        cyc(8);
    endtask
    task automatic rd(input int n);
        u_amprbc_host.readFrame(n, word);
    endtask
    task automatic prot(input int i);
        sense.overVolt <= (i == 0);
        sense.battOver22 <= (i == 1);
        sense.regTempMax <= (i == 2);
        sense.regOverTemp <= {3'h0, i == 3};
        cyc(10);
    endtask
    initial begin
        #200000;
        errors++;
        test_done();
    end
    initial begin
        reset = 1'b1;
        diagEnable = 1'b0;
        sense = '0;
        sense.standby = 1'b1;
        errors = 0;
        checks = 0;
        cyc(2);
        check("powerRst", 32'(power), 32'h000c);
        check("diagRst", 32'(diagOe), 32'h1);
        check("diagPin", 32'(diagOut), 32'h0);
        reset <= 1'b0;
        cyc(10);
        rd(4);
        check("porFlag", word, 32'h8000);
        wr(40'h00_10_60_54_3d);
        check("power", 32'(power), 32'h1a3f);
        check("diagOn", 32'(diagOe), 32'h0);
        check("ampOn", 32'(ampOn), 32'h1);
        cyc(SOFT + 10);
        check("full", 32'(pairFull), 32'h3);
        rd(4);
        rd(4);
        check("porClear", word, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr({8'h00, ((i < 4) ? 8'h10 : 8'h00), gainTab[i], 8'h54, 8'h3d});
            check("bias", 32'(lineDriverBias), 32'(i == 3));
        end
        for (int i = 0; i < 4; i++) begin
            wr({muteTab[i][15:8], 8'h00, 8'h60, muteTab[i][23:16], 8'h3d});
            cyc(4);
            check("early", 32'(pairSilent), 32'(muteTab[i][5:4]));
            cyc(SOFT);
            check("late", 32'(pairSilent), 32'(muteTab[i][1:0]));
            wr(40'h00_00_60_54_3d);
            cyc(4);
            check("fullEarly", 32'(pairFull),
                {30'h0, ~muteTab[i][1:0]});
            cyc(SOFT);
            check("fullLate", 32'(pairFull), 32'h3);
        end
        diagEnable <= 1'b1;
        sense.ampFail <= 32'h8;
        cyc(10);
        check("diagLive", 32'(diagOe), 32'h1);
        sense.ampFail <= 32'h0;
        cyc(10);
        check("diagFree", 32'(diagOe), 32'h0);
        rd(3);
        check("part", word, 32'h8);
        rd(4);
        check("all4", word, 32'h8);
        rd(4);
        check("cleared", word, 32'h0);
        sense.regTempHigh <= 1'b1;
        cyc(30);
        check("tempAmp", 32'(ampOn), 32'h0);
        check("tempDiag", 32'(diagOe), 32'h1);
        sense.regTempHigh <= 1'b0;
        cyc(10);
        rd(4);
        check("tempFlag", word, 32'h4000);
        for (int i = 0; i < 4; i++) begin
            prot(i);
            check("prot", 32'(power), 32'(protTab[i]));
            prot(4);
            check("restore", 32'(power), 32'h1a3f);
        end
        sense.standby <= 1'b0;
        // Long enough for the checker's standby window
        cyc(HARD + 20);
        check("stbAmp", 32'(ampOn), 32'h0);
        check("stbMute", 32'(pairSilent), 32'h3);
        sense.standby <= 1'b1;
        cyc(10);
        check("porPower", 32'(power), 32'h000c);
        check("porBias", 32'(lineDriverBias), 32'h0);
        check("porDiag", 32'(diagOe), 32'h1);
        rd(4);
        check("porAgain", word, 32'h8000);
        test_done();
    end
endmodule
`default_nettype wire
